// ---- design/dma_irq_top.sv ----
// dma interrupt enable gating and lost-frame counters behind a classic wishbone slave
// How it works
// R1: reset or a software reset clears every enable bit of the mask register.
// R2: bit 16 gates transmit-done, transmit-no-buffer and receive-done as the normal group.
// R3: bit 15 gates transmit-stopped, receive-no-buffer and receive-stopped as the abnormal group.
// R4: receive watchdog interrupts only with bit 9 and bit 15 set.
// R5: receive-stopped interrupts only with bit 8 and bit 15 set.
// R6: receive-no-buffer interrupts only with bit 7 and bit 15 set.
// R7: receive-done interrupts only with bit 6 and bit 15 set, and here also needs bit 16.
// R8: transmit-no-buffer interrupts only with bit 2 and bit 16 set.
// R9: transmit-stopped interrupts only with bit 1 and bit 15 set.
// R10: transmit-done interrupts only with bit 0 and bit 16 set.
// R11: bits 27:17 count frames lost to a full receive fifo.
// R12: bit 28 flags a wrap of the fifo-full count and clears on read.
// R13: bits 15:0 count frames dropped for want of a receive buffer.
// R14: bit 16 flags a wrap of the no-buffer count and clears on read.
// R15: a read of the lost-frame register returns both counts then zeroes them.
// R16: a receive descriptor fetch that finds no owned descriptor suspends and raises rx_no_buffer_flag, and here raises it only when not already suspended.
// R17: a counter stepping from all ones wraps to zero and sets its sticky wrap bit.
//
// Register access over Wishbone was decided locally.
`include "dma_irq_cfg.svh"
module dma_irq_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        soft_rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // dma event inputs, one-cycle pulses
    input  wire logic        tx_done_i,
    input  wire logic        tx_stop_i,
    input  wire logic        tx_no_buffer_i,
    input  wire logic        rx_done_i,
    input  wire logic        rx_stop_i,
    input  wire logic        rx_watchdog_i,
    input  wire logic        rx_desc_none_i,
    input  wire logic        fifo_full_drop_i,
    input  wire logic        no_buffer_drop_i,
    input  wire logic        rx_resume_i,
    // outputs
    output logic             irq_o,
    output logic             rx_suspended_o
);
    // mask register and its group summaries
    logic [31:0] dma_event_mask_reg;
    logic [31:0] dma_event_mask_next;
    logic [8:0]  event_flags_reg;
    logic        rx_suspended_reg;
    dma_irq_pkg::bus_state_e bus_state_reg;

    wire logic normal_summary_enable   = dma_event_mask_reg[`NRM_SUM_BIT];
    wire logic abnormal_summary_enable = dma_event_mask_reg[`ABN_SUM_BIT];

    // bus decode
    wire logic req      = cyc_i & stb_i & (bus_state_reg == dma_irq_pkg::BUS_IDLE);
    wire logic hit_mask = adr_i == `MASK_REG_OFS;
    wire logic hit_lost = adr_i == `LOST_REG_OFS;
    wire logic hit_evt  = adr_i == `EVENT_REG_OFS;
    wire logic hit_susp = adr_i == `SUSPEND_REG_OFS;
    wire logic wr_mask  = req & we_i & hit_mask;
    wire logic wr_evt   = req & we_i & hit_evt;
    wire logic rd_lost  = req & ~we_i & hit_lost;

    // byte-lane merge of a write into the mask, only defined bits are writable
    wire logic [31:0] lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign dma_event_mask_next = (dma_event_mask_reg & ~(lane_mask & `MASK_RW_BITS))
                               | (dat_i & lane_mask & `MASK_RW_BITS);

    // two lost-frame counters
    drop_counter_if #(.W(`FIFO_CNT_W))  fifo_cnt_if ();
    drop_counter_if #(.W(`NOBUF_CNT_W)) nobuf_cnt_if ();

    assign fifo_cnt_if.bump   = fifo_full_drop_i;   // see R11
    assign fifo_cnt_if.clear  = rd_lost;            // see R12
    assign nobuf_cnt_if.bump  = no_buffer_drop_i;   // see R13
    assign nobuf_cnt_if.clear = rd_lost;            // see R14

    drop_counter #(.W(`FIFO_CNT_W)) u_fifo_cnt (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .port  (fifo_cnt_if.owner)
    );
    drop_counter #(.W(`NOBUF_CNT_W)) u_nobuf_cnt (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .port  (nobuf_cnt_if.owner)
    );

    // lost-frame register image
    wire logic [31:0] lost_image = {3'h0,
                                    fifo_cnt_if.wrap,      // see R12
                                    fifo_cnt_if.count,     // see R11
                                    nobuf_cnt_if.wrap,     // see R14
                                    nobuf_cnt_if.count};   // see R13

    // read data mux, unmapped addresses read as zero
    wire logic [31:0] rd_data = hit_mask ? dma_event_mask_reg :
                                hit_lost ? lost_image :
                                hit_evt  ? {23'h0, event_flags_reg} :
                                hit_susp ? {31'h0, rx_suspended_reg} : 32'h0000_0000;

    // a fetch finding no owned descriptor raises the no-buffer flag; while
    // already suspended a repeated empty fetch raises nothing new
    wire logic rx_no_buffer_event = rx_desc_none_i & ~rx_suspended_reg;  // see R16

    // raw events in status bit order
    wire logic [8:0] raw_events;
    assign raw_events[`TX_DONE_BIT]  = tx_done_i;
    assign raw_events[`TX_STOP_BIT]  = tx_stop_i;
    assign raw_events[`TX_NOBUF_BIT] = tx_no_buffer_i;
    assign raw_events[5:3]           = 3'h0;
    assign raw_events[`RX_DONE_BIT]  = rx_done_i;
    assign raw_events[`RX_NOBUF_BIT] = rx_no_buffer_event;
    assign raw_events[`RX_STOP_BIT]  = rx_stop_i;

    // gated interrupt sources; receive-done needs both summaries because its
    // own enable names the abnormal group while the grouping puts it in normal
    wire logic tx_done_irq  = event_flags_reg[`TX_DONE_BIT]  & dma_event_mask_reg[`TX_DONE_BIT]
                            & normal_summary_enable;                           // see R10 see R2
    wire logic tx_nobuf_irq = event_flags_reg[`TX_NOBUF_BIT] & dma_event_mask_reg[`TX_NOBUF_BIT]
                            & normal_summary_enable;                           // see R8 see R2
    wire logic rx_done_irq  = event_flags_reg[`RX_DONE_BIT]  & dma_event_mask_reg[`RX_DONE_BIT]
                            & abnormal_summary_enable & normal_summary_enable; // see R7 see R2
    wire logic tx_stop_irq  = event_flags_reg[`TX_STOP_BIT]  & dma_event_mask_reg[`TX_STOP_BIT]
                            & abnormal_summary_enable;                         // see R9 see R3
    wire logic rx_nobuf_irq = event_flags_reg[`RX_NOBUF_BIT] & dma_event_mask_reg[`RX_NOBUF_BIT]
                            & abnormal_summary_enable;                         // see R6 see R3
    wire logic rx_stop_irq  = event_flags_reg[`RX_STOP_BIT]  & dma_event_mask_reg[`RX_STOP_BIT]
                            & abnormal_summary_enable;                         // see R5 see R3
    wire logic rx_wdog_irq  = rx_watchdog_i & dma_event_mask_reg[`RX_WDOG_BIT]
                            & abnormal_summary_enable;                         // see R4

    wire logic irq_next = tx_done_irq | tx_nobuf_irq | rx_done_irq | tx_stop_irq
                        | rx_nobuf_irq | rx_stop_irq | rx_wdog_irq;

    // mask register; software reset clears enables like the hardware reset
    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst_i) begin
            dma_event_mask_reg <= `MASK_RESET;  // see R1
        end else if (wr_mask) begin
            dma_event_mask_reg <= dma_event_mask_next;
        end
    end

    // sticky event flags, write one to clear; a new event beats the clear so
    // software never loses an event that lands in its own clearing write
    wire logic [8:0] flag_clear_bits  = wr_evt ? dat_i[8:0] : 9'h000;
    wire logic [8:0] event_flags_next = (event_flags_reg & ~flag_clear_bits) | raw_events;

    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst_i) begin
            event_flags_reg <= 9'h000;
        end else begin
            event_flags_reg <= event_flags_next;
        end
    end

    // receive suspend state: entered on an empty list, left on resume; an
    // empty list in the resume cycle keeps the engine suspended
    wire logic rx_suspended_next = rx_desc_none_i | (rx_suspended_reg & ~rx_resume_i);  // see R16

    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst_i) begin
            rx_suspended_reg <= 1'b0;
        end else begin
            rx_suspended_reg <= rx_suspended_next;
        end
    end

    // registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst_i) begin
            irq_o          <= 1'b0;
            rx_suspended_o <= 1'b0;
        end else begin
            irq_o          <= irq_next;
            rx_suspended_o <= rx_suspended_reg;
        end
    end

    // wishbone handshake: one ack a cycle after the request, then rest until the
    // strobe drops so a held strobe cannot be taken twice
    dma_irq_pkg::bus_state_e bus_state_next;
    logic                    ack_next;
    logic [31:0]             dat_next;

    always_comb begin
        bus_state_next = bus_state_reg;
        ack_next       = 1'b0;
        dat_next       = dat_o;
        case (bus_state_reg)
            dma_irq_pkg::BUS_IDLE: begin
                if (req) begin
                    ack_next       = 1'b1;
                    dat_next       = rd_data;  // see R15
                    bus_state_next = dma_irq_pkg::BUS_ACK;
                end
            end
            dma_irq_pkg::BUS_ACK: begin
                bus_state_next = dma_irq_pkg::BUS_WAIT;
            end
            dma_irq_pkg::BUS_WAIT: begin
                if (!(cyc_i && stb_i)) begin
                    bus_state_next = dma_irq_pkg::BUS_IDLE;
                end
            end
            default: begin
                bus_state_next = dma_irq_pkg::BUS_IDLE;
            end
        endcase
    end

    // bus registers; a software reset leaves a running handshake alone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_state_reg <= dma_irq_pkg::BUS_IDLE;
            ack_o         <= 1'b0;
            dat_o         <= 32'h0000_0000;
        end else begin
            bus_state_reg <= bus_state_next;
            ack_o         <= ack_next;
            dat_o         <= dat_next;
        end
    end
endmodule : dma_irq_top

// ---- design/dma_irq_cfg.svh ----
// register offsets, field positions and reset values of the dma event mask and lost-frame counters
`ifndef DMA_IRQ_CFG_SVH
`define DMA_IRQ_CFG_SVH

`define MASK_REG_OFS      8'h1c
`define LOST_REG_OFS      8'h20
`define EVENT_REG_OFS     8'h24
`define SUSPEND_REG_OFS   8'h28
`define ADDR_W            8

`define TX_DONE_BIT       0
`define TX_STOP_BIT       1
`define TX_NOBUF_BIT      2
`define RX_DONE_BIT       6
`define RX_NOBUF_BIT      7
`define RX_STOP_BIT       8
`define RX_WDOG_BIT       9
`define ABN_SUM_BIT       15
`define NRM_SUM_BIT       16

`define MASK_RW_BITS      32'h0001_c7e7
`define MASK_RESET        32'h0000_0000

`define FIFO_CNT_LSB      17
`define FIFO_CNT_W        11
`define FIFO_WRAP_BIT     28
`define NOBUF_CNT_LSB     0
`define NOBUF_CNT_W       16
`define NOBUF_WRAP_BIT    16

`endif

// ---- design/dma_irq_pkg.sv ----
// shared types of the dma event mask block
package dma_irq_pkg;
    typedef logic [31:0] word_t;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ACK  = 3'b010,
        BUS_WAIT = 3'b100
    } bus_state_e;
endpackage : dma_irq_pkg

// ---- design/drop_counter_if.sv ----
// carrier between the top module and one lost-frame counter
interface drop_counter_if #(parameter int W = 16);
    logic         bump;
    logic         clear;
    logic [W-1:0] count;
    logic         wrap;
    modport owner (input bump, input clear, output count, output wrap);
    modport user  (output bump, output clear, input count, input wrap);
endinterface : drop_counter_if

// ---- design/drop_counter.sv ----
// one saturating-free lost-frame counter with sticky wrap flag
module drop_counter #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    drop_counter_if.owner     port
);
    logic [W-1:0] count_reg;
    logic         wrap_reg;
    wire  logic   all_ones = &count_reg;

    // refuse widths that the lost-frame register cannot hold
    if (W < 1 || W > 31) begin : g_bad_width
        $error("drop_counter width out of range");
    end

    // clear on read; a frame lost in the read cycle still counts as one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= '0;
            wrap_reg  <= 1'b0;
        end else begin
            if (port.clear) begin
                count_reg <= port.bump ? W'(1) : '0;
                wrap_reg  <= 1'b0;
            end else if (port.bump) begin
                count_reg <= count_reg + W'(1);  // wraps to zero, see R17
                if (all_ones) wrap_reg <= 1'b1;  // see R17
            end
        end
    end

    assign port.count = count_reg;
    assign port.wrap  = wrap_reg;
endmodule : drop_counter

// ---- tb/dma_irq_monitor.sv ----
// assertion checker for the dma event mask block
module dma_irq_monitor (
    // clock, reset, bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        soft_rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // events and outputs
    input wire logic        tx_done_i,
    input wire logic        rx_done_i,
    input wire logic        rx_watchdog_i,
    input wire logic        rx_desc_none_i,
    input wire logic        irq_o,
    input wire logic        rx_suspended_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] RW = 32'h0001_c7e7;
    logic [31:0] mask_reg;
    // shadow mask, one cycle behind the design so gating checks stay conservative
    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst_i) begin
            mask_reg <= 32'h0000_0000;
        end else if (ack_o && we_i && adr_i == 8'h1c) begin
            for (int i = 0; i < 4; i++) begin
                if (sel_i[i]) begin
                    mask_reg[i*8 +: 8] <= dat_i[i*8 +: 8] & RW[i*8 +: 8];
                end
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_answers: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_o && !rx_suspended_o)
        else $error("outputs active after reset");
    a_soft_clear: assert property (soft_rst_i |=> ##1 !irq_o) else $error("irq after soft reset");
    a_mask_readback: assert property (ack_o && !we_i && adr_i == 8'h1c |-> dat_o == mask_reg)
        else $error("mask readback wrong");
    a_unmapped_zero: assert property (ack_o && !we_i && adr_i == 8'h40 |-> dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_groups_off: assert property (
        !mask_reg[15] && !mask_reg[16] && $past(mask_reg[16:15]) == 2'b00 |-> !irq_o)
        else $error("irq with both summaries clear");
    a_wdog_gated: assert property (rx_watchdog_i && mask_reg[9] && mask_reg[15] |-> ##[1:2] irq_o)
        else $error("watchdog irq missing");
    a_tx_done_gated: assert property (tx_done_i && mask_reg[0] && mask_reg[16] |-> ##[1:2] irq_o)
        else $error("tx done irq missing");
    a_rx_done_gated: assert property (
        rx_done_i && &{mask_reg[6], mask_reg[15], mask_reg[16]} |-> ##[1:2] irq_o)
        else $error("rx done irq missing");
    a_suspend_entry: assert property (rx_desc_none_i && !rx_suspended_o |-> ##[1:2] rx_suspended_o)
        else $error("suspend not entered");
    c_lost_read: cover property (ack_o && !we_i && adr_i == 8'h20 && dat_o != 32'h0000_0000);
    c_irq_rise: cover property ($rose(irq_o));
    c_suspend: cover property ($rose(rx_suspended_o));
endmodule : dma_irq_monitor

bind dma_irq_top dma_irq_monitor dma_irq_monitor_inst (
    .clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tx_done_i(tx_done_i),
    .rx_done_i(rx_done_i), .rx_watchdog_i(rx_watchdog_i), .rx_desc_none_i(rx_desc_none_i), .irq_o(irq_o),
    .rx_suspended_o(rx_suspended_o)
);

// ---- tb/tb_dma_irq_top.sv ----
// self-checking bench for the dma event mask and lost-frame counters
module tb_dma_irq_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, rst_i, soft_rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, rx_suspended_o;
    logic        fifo_full_drop_i, no_buffer_drop_i, rx_resume_i;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [6:0]  ev;
    int          num_errors, checked;
    // per event: its enable bit and the summary pair {16,15} it needs
    int          en_bit[7] = '{0, 1, 2, 6, 8, 9, 7};
    logic [1:0]  need[7]   = '{2'b10, 2'b01, 2'b10, 2'b11, 2'b01, 2'b01, 2'b01};

    dma_irq_top dma_irq_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tx_done_i(ev[0]),
        .tx_stop_i(ev[1]), .tx_no_buffer_i(ev[2]), .rx_done_i(ev[3]), .rx_stop_i(ev[4]), .rx_watchdog_i(ev[5]),
        .rx_desc_none_i(ev[6]), .fifo_full_drop_i(fifo_full_drop_i), .no_buffer_drop_i(no_buffer_drop_i),
        .rx_resume_i(rx_resume_i), .irq_o(irq_o), .rx_suspended_o(rx_suspended_o)
    );

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // classic cycle; data is taken at the edge where ack is sampled high
    task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= we;
        adr_i <= adr;
        sel_i <= sel;
        dat_i <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ack_o !== 1'b1) begin
            num_errors++;
            tally_and_finish();
        end
    endtask : bus

    task automatic soft_reset();
        @(posedge clk_i);
        soft_rst_i <= 1'b1;
        @(posedge clk_i);
        soft_rst_i <= 1'b0;
    endtask : soft_reset

    // one event pulse; watches irq over three cycles since the watchdog irq lasts one
    task automatic fire(input int k, output logic seen);
        seen = 1'b0;
        @(posedge clk_i);
        ev[k] <= 1'b1;
        @(posedge clk_i);
        ev[k] <= 1'b0;
        repeat (3) begin
            @(posedge clk_i);
            seen = seen | irq_o;
        end
    endtask : fire

    task automatic drops(input int nf, input int nb);
        for (int i = 0; i <= nb; i++) begin
            @(posedge clk_i);
            fifo_full_drop_i <= (i < nf);
            no_buffer_drop_i <= (i < nb);
        end
    endtask : drops

    task automatic t_regs();
        bus(1'b0, 8'h1c, 4'hf, 32'h0000_0000);
        check("mask reset", rd, 32'h0000_0000);
        bus(1'b1, 8'h1c, 4'hf, 32'hffff_ffff);
        bus(1'b0, 8'h1c, 4'hf, 32'h0000_0000);
        check("mask rw", rd, 32'h0001_c7e7);
        bus(1'b1, 8'h1c, 4'b0100, 32'h0000_0000);
        bus(1'b0, 8'h1c, 4'hf, 32'h0000_0000);
        check("mask lane", rd, 32'h0000_c7e7);
        bus(1'b1, 8'h40, 4'hf, 32'hffff_ffff);
        bus(1'b0, 8'h40, 4'hf, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        soft_reset();
        bus(1'b0, 8'h1c, 4'hf, 32'h0000_0000);
        check("mask soft reset", rd, 32'h0000_0000);
    endtask : t_regs

    // every event under every mix of its enable and the two summaries
    task automatic t_gating();
        logic seen;
        for (int k = 0; k < 7; k++) begin
            for (int j = 0; j < 8; j++) begin
                soft_reset();
                bus(1'b1, 8'h1c, 4'hf, {15'h0000, j[1], j[0], 15'h0000} | (j[2] ? 32'h0000_0001 << en_bit[k] : 32'h0000_0000));
                fire(k, seen);
                check("irq gate", seen, 32'(j[2] && (j[1:0] & need[k]) == need[k]));
            end
        end
    endtask : t_gating

    task automatic t_suspend();
        logic seen;
        soft_reset();
        fire(6, seen);
        check("suspended", rx_suspended_o, 32'h0000_0001);
        bus(1'b0, 8'h28, 4'hf, 32'h0000_0000);
        check("suspend state", rd, 32'h0000_0001);
        bus(1'b0, 8'h24, 4'hf, 32'h0000_0000);
        check("no buffer flag", rd, 32'h0000_0080);
        // clear the flag, then an empty fetch while suspended must not raise it again
        bus(1'b1, 8'h24, 4'hf, 32'h0000_0080);
        fire(6, seen);
        bus(1'b0, 8'h24, 4'hf, 32'h0000_0000);
        check("flag stays clear", rd, 32'h0000_0000);
        @(posedge clk_i);
        rx_resume_i <= 1'b1;
        @(posedge clk_i);
        rx_resume_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("resumed", rx_suspended_o, 32'h0000_0000);
        bus(1'b0, 8'h28, 4'hf, 32'h0000_0000);
        check("resume state", rd, 32'h0000_0000);
    endtask : t_suspend

    task automatic t_counters();
        drops(3, 5);
        bus(1'b0, 8'h20, 4'hf, 32'h0000_0000);
        check("lost counts", rd, 32'h0006_0005);
        bus(1'b0, 8'h20, 4'hf, 32'h0000_0000);
        check("lost cleared", rd, 32'h0000_0000);
        drops(2049, 65537);
        bus(1'b0, 8'h20, 4'hf, 32'h0000_0000);
        check("lost wrap", rd, 32'h1003_0001);
        bus(1'b0, 8'h20, 4'hf, 32'h0000_0000);
        check("wrap cleared", rd, 32'h0000_0000);
    endtask : t_counters

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // main sequence
    initial begin
        {rst_i, soft_rst_i, cyc_i, stb_i, we_i, fifo_full_drop_i, no_buffer_drop_i, rx_resume_i} = 8'h80;
        adr_i = 8'h00;
        sel_i = 4'h0;
        dat_i = 32'h0000_0000;
        ev = 7'h00;
        num_errors = 0;
        checked = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_gating();
        t_suspend();
        t_counters();
        tally_and_finish();
    end
endmodule : tb_dma_irq_top
